// [fbmrc_pkg.sv]
// Constants shared by the boot-mode, reset and flash sequencing block.
`default_nettype none
package fbmrc_pkg;
  localparam int CLK_FREQ_MHZ = 125;
  localparam int DATA_W = 32;
  localparam int TMR_W = 24;
  localparam int ADDR_W = 4;
  localparam int NUM_BLOCKS = 4;
  localparam int CMD_W = 4;
  localparam int GEAR_W = 3;

  // Typical self-timed operation lengths and read recovery time.
  localparam int PROG_TIME_US = 1250;
  localparam int ERASE_TIME_MS = 100;
  localparam int RECOVER_TIME_MS = 2;
  localparam logic [TMR_W-1:0] PROG_CYC =
    TMR_W'(PROG_TIME_US * CLK_FREQ_MHZ);
  localparam logic [TMR_W-1:0] ERASE_CYC =
    TMR_W'(ERASE_TIME_MS * 1000 * CLK_FREQ_MHZ);
  localparam logic [TMR_W-1:0] RECOVER_CYC =
    TMR_W'(RECOVER_TIME_MS * 1000 * CLK_FREQ_MHZ);

  // Clock gear codes; the undivided ratio is forced by every reset.
  localparam logic [GEAR_W-1:0] GEAR_1_1 = 3'h0;

  // Reset values and the erased word value.
  localparam logic PIN_RST_N_RST = 1'b0;
  localparam logic STRAP_RST = 1'b1;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;

  // Field positions of the status word returned while an operation runs.
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;

  // Command codes.
  localparam logic [CMD_W-1:0] CMD_PROGRAM = 4'h1;
  localparam logic [CMD_W-1:0] CMD_BLOCK_ERASE = 4'h2;
  localparam logic [CMD_W-1:0] CMD_CHIP_ERASE = 4'h3;
  localparam logic [CMD_W-1:0] CMD_PROTECT = 4'h4;
  localparam logic [CMD_W-1:0] CMD_READ_LOCK = 4'h5;
  localparam logic [CMD_W-1:0] CMD_PROT_CLEAR = 4'h6;
  localparam logic [CMD_W-1:0] CMD_SUSPEND = 4'h7;
  localparam logic [CMD_W-1:0] CMD_RESUME = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PROG = 3'b010,
    ST_ERASE = 3'b100
  } fbmrc_state_t;
endpackage : fbmrc_pkg
`default_nettype wire

// [fbmrc_properties.sv]
// Port-level assertions for the flash boot and reset controller.
`default_nettype none
module fbmrc_properties #(
  parameter logic [23:0] PROG_CYCLES = 24'h14,
  parameter logic [23:0] ERASE_CYCLES = 24'h28,
  parameter logic [23:0] RECOVER_CYCLES = 24'h1e
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic CMD_VALID_I,
  input wire logic [3:0] CMD_CODE_I,
  input wire logic [3:0] CMD_ADDR_I,
  input wire logic RD_EXT_I,
  input wire logic CMD_READY_O,
  input wire logic CMD_REFUSED_O,
  input wire logic RD_VALID_O,
  input wire logic RD_DENIED_O,
  input wire logic [31:0] RD_DATA_O,
  input wire logic CORE_RESET_O,
  input wire logic BOOT_FROM_ROM_O,
  input wire logic [2:0] CLK_GEAR_O,
  input wire logic FLASH_BUSY_O,
  input wire logic FLASH_READ_READY_O,
  input wire logic [3:0] PROTECT_O,
  input wire logic READ_LOCK_O
);
  logic [23:0] busy_len_ff;
  logic [23:0] wait_len_ff;
  logic busy_was_ff;
  logic cut_ff;
  wire logic take = CMD_VALID_I && CMD_READY_O;
  wire logic [1:0] blk = CMD_ADDR_I[3:2];
  // Counters stand in for long repetitions, which the tools cannot unroll.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      busy_len_ff <= '0;
      wait_len_ff <= '0;
      busy_was_ff <= 1'b0;
      cut_ff <= 1'b0;
    end else begin
      busy_len_ff <= FLASH_BUSY_O ? busy_len_ff + 24'h1 : '0;
      wait_len_ff <= (CORE_RESET_O || FLASH_READ_READY_O) ? '0 :
        wait_len_ff + 24'h1;
      busy_was_ff <= FLASH_BUSY_O;
      cut_ff <= (CORE_RESET_O && busy_was_ff) ||
        (cut_ff && !FLASH_READ_READY_O);
    end
  end
  default clocking dc @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);
  a_gear_undivided: assert property (
    $fell(CORE_RESET_O) |-> CLK_GEAR_O == fbmrc_pkg::GEAR_1_1)
    else $error("gear not undivided after reset");
  a_boot_held: assert property (
    !CORE_RESET_O && !$past(CORE_RESET_O) |-> $stable(BOOT_FROM_ROM_O))
    else $error("boot source moved outside reset");
  a_busy_no_read: assert property (
    FLASH_BUSY_O |-> !FLASH_READ_READY_O)
    else $error("array readable while busy");
  a_lock_hides: assert property (
    RD_VALID_O && $past(RD_EXT_I) && $past(READ_LOCK_O)
      |-> RD_DENIED_O && RD_DATA_O == 32'h0)
    else $error("locked data reached external reader");
  a_no_suspend: assert property (
    take && (CMD_CODE_I == fbmrc_pkg::CMD_SUSPEND ||
      CMD_CODE_I == fbmrc_pkg::CMD_RESUME) |=> CMD_REFUSED_O && !FLASH_BUSY_O)
    else $error("suspend or resume accepted");
  a_prot_refuse: assert property (
    take && CMD_CODE_I == fbmrc_pkg::CMD_PROGRAM && PROTECT_O[blk]
      |=> CMD_REFUSED_O && !FLASH_BUSY_O)
    else $error("protected block programmed");
  a_prot_by_cmd: assert property (
    (PROTECT_O & ~$past(PROTECT_O)) != 4'h0
      |-> $past(take) && $past(CMD_CODE_I) == fbmrc_pkg::CMD_PROTECT)
    else $error("protection set without command");
  // Busy also covers the cycle in which the registered done pulses, so it stands one beyond the count.
  a_busy_length: assert property (
    $fell(FLASH_BUSY_O) && !CORE_RESET_O
      |-> busy_len_ff == PROG_CYCLES + 24'h1 ||
        busy_len_ff == ERASE_CYCLES + 24'h1)
    else $error("self-timed operation length wrong");
  a_busy_status: assert property (
    RD_VALID_O && $past(FLASH_BUSY_O) && !RD_DENIED_O
      |-> (RD_DATA_O & 32'hffffff3f) == 32'h0)
    else $error("array data read while busy");
  a_recover_wait: assert property (
    $rose(FLASH_READ_READY_O) && cut_ff |-> wait_len_ff >= RECOVER_CYCLES)
    else $error("reads returned too soon after cut");
endmodule : fbmrc_properties
`default_nettype wire

// [fbmrc_reset_drv.sv]
// Behavioural model of the external reset driver and start-up strap.
`default_nettype none
module fbmrc_reset_drv #(
  parameter int HOLD = 63,
  parameter int COLD = 175000
) (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic rom_i,
  output logic rst_n_o,
  output logic strap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // HOLD covers both twelve clocks and half a microsecond at 125 MHz.
  int cnt_ff = COLD;
  int post_ff = 2;
  logic rom_ff = 1'b0;
  logic strap_ff = 1'b1;
  assign rst_n_o = (cnt_ff == 0);
  assign strap_o = strap_ff;
  // The strap has no pull, so once released it toggles to expose late use.
  always @(posedge clk_i) begin
    if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
      post_ff <= 2;
      strap_ff <= ~rom_ff;
    end else begin
      if (go_i) begin
        cnt_ff <= HOLD;
        rom_ff <= rom_i;
      end
      if (post_ff != 0) post_ff <= post_ff - 1;
      else strap_ff <= ~strap_ff;
    end
  end
endmodule : fbmrc_reset_drv
`default_nettype wire

// [fbmrc_sync.sv]
// Two-stage synchroniser for pin inputs.
`default_nettype none
module fbmrc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule : fbmrc_sync
`default_nettype wire

// [fbmrc_test.sv]
// Self-checking bench for the flash boot and reset controller.
`default_nettype none
module fbmrc_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [3:0] code;
    logic [3:0] addr;
    logic [31:0] data;
    logic refused;
    logic [31:0] word;
  } fbmrc_row_t;
  localparam logic [3:0] PG = fbmrc_pkg::CMD_PROGRAM;
  localparam logic [3:0] BE = fbmrc_pkg::CMD_BLOCK_ERASE;
  localparam logic [3:0] CE = fbmrc_pkg::CMD_CHIP_ERASE;
  fbmrc_row_t rows [13];
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic go = 1'b0;
  logic rom = 1'b0;
  logic gear_wr = 1'b0;
  logic [2:0] gear_sel = 3'h0;
  logic cmd_valid = 1'b0;
  logic [3:0] cmd_code = 4'h0;
  logic [3:0] cmd_addr = 4'h0;
  logic [31:0] cmd_data = 32'h0;
  logic rd_req = 1'b0;
  logic rd_ext = 1'b0;
  logic [3:0] rd_addr = 4'h0;
  logic pin_n, strap, cmd_ready, cmd_refused, rd_valid, rd_denied;
  logic core_reset, boot_rom, busy, rd_ready, rd_lock, seen_ref;
  logic [31:0] rd_data, d1;
  logic [2:0] gear;
  logic [3:0] protect;
  int n_errors = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  fbmrc_reset_drv #(.COLD(200)) u_drv (.clk_i(clk), .go_i(go), .rom_i(rom),
    .rst_n_o(pin_n), .strap_o(strap));
  fbmrc_top #(.PROG_CYCLES(24'h14), .ERASE_CYCLES(24'h28),
    .RECOVER_CYCLES(24'h1e)) u_dut (
    .SYS_CLK_I(clk), .RESET_I(reset), .RESET_N_PIN_I(pin_n),
    .PORT_F_LINE_ZERO_I(strap), .GEAR_WR_I(gear_wr), .GEAR_SEL_I(gear_sel),
    .CMD_VALID_I(cmd_valid), .CMD_CODE_I(cmd_code), .CMD_ADDR_I(cmd_addr),
    .CMD_DATA_I(cmd_data), .RD_REQ_I(rd_req), .RD_EXT_I(rd_ext),
    .RD_ADDR_I(rd_addr), .CMD_READY_O(cmd_ready),
    .CMD_REFUSED_O(cmd_refused), .RD_VALID_O(rd_valid),
    .RD_DENIED_O(rd_denied), .RD_DATA_O(rd_data), .CORE_RESET_O(core_reset),
    .BOOT_FROM_ROM_O(boot_rom), .CLK_GEAR_O(gear), .FLASH_BUSY_O(busy),
    .FLASH_READ_READY_O(rd_ready), .PROTECT_O(protect),
    .READ_LOCK_O(rd_lock));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  function automatic logic pick(input int k);
    case (k)
      0: return cmd_ready;
      1: return !busy;
      2: return rd_ready;
      3: return !core_reset;
      default: return core_reset;
    endcase
  endfunction : pick
  task automatic wait_for(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (pick(k) !== 1'b1 && n < 300);
    if (pick(k) !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
  endtask : wait_for
  task automatic do_cmd(input logic [3:0] code, input logic [3:0] addr,
      input logic [31:0] data, input logic hold);
    wait_for(0);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_addr <= addr;
    cmd_data <= data;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    seen_ref = cmd_refused;
    if (!hold) wait_for(1);
  endtask : do_cmd
  task automatic do_read(input logic [3:0] addr, input logic ext);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_addr <= addr;
    rd_ext <= ext;
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
    check(32'(rd_valid), 32'h1);
  endtask : do_read
  task automatic pin_reset(input logic r);
    @(posedge clk);
    go <= 1'b1;
    rom <= r;
    @(posedge clk);
    go <= 1'b0;
    wait_for(4);
    wait_for(3);
  endtask : pin_reset
  initial begin
    rows[0] = '{CE, 4'h0, 32'h0, 1'b0, 32'hffffffff};
    rows[1] = '{PG, 4'h1, 32'h0000ff0f, 1'b0, 32'h0000ff0f};
    rows[2] = '{PG, 4'h1, 32'hfffff0ff, 1'b0, 32'h0000f00f};
    rows[3] = '{BE, 4'h1, 32'h0, 1'b0, 32'hffffffff};
    rows[4] = '{fbmrc_pkg::CMD_PROTECT, 4'h4, 32'h0, 1'b0, 32'hffffffff};
    rows[5] = '{PG, 4'h5, 32'h0, 1'b1, 32'hffffffff};
    rows[6] = '{BE, 4'h6, 32'h0, 1'b1, 32'hffffffff};
    rows[7] = '{CE, 4'h0, 32'h0, 1'b1, 32'hffffffff};
    rows[8] = '{fbmrc_pkg::CMD_SUSPEND, 4'h0, 32'h0, 1'b1, 32'hffffffff};
    rows[9] = '{fbmrc_pkg::CMD_RESUME, 4'h0, 32'h0, 1'b1, 32'hffffffff};
    rows[10] = '{4'hf, 4'h0, 32'h0, 1'b1, 32'hffffffff};
    rows[11] = '{fbmrc_pkg::CMD_PROT_CLEAR, 4'h4, 32'h0, 1'b0, 32'hffffffff};
    rows[12] = '{PG, 4'h5, 32'h12345678, 1'b0, 32'h12345678};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    wait_for(3);
    check(32'(boot_rom), 32'h0);
    check(32'(gear), 32'h0);
    foreach (rows[i]) begin
      do_cmd(rows[i].code, rows[i].addr, rows[i].data, 1'b0);
      check(32'(seen_ref), 32'(rows[i].refused));
      do_read(rows[i].addr, 1'b0);
      check(rd_data, rows[i].word);
    end
    check(32'(protect), 32'h0);
    do_cmd(fbmrc_pkg::CMD_READ_LOCK, 4'h0, 32'h0, 1'b0);
    check(32'(rd_lock), 32'h1);
    do_read(4'h5, 1'b1);
    check(32'(rd_denied), 32'h1);
    check(rd_data, 32'h0);
    do_read(4'h5, 1'b0);
    check(rd_data, 32'h12345678);
    do_cmd(PG, 4'h2, 32'h0, 1'b1);
    check(32'(rd_ready), 32'h0);
    @(posedge clk);
    rd_req <= 1'b1;
    @(posedge clk);
    #1;
    d1 = rd_data;
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
    check(32'(d1[6] ^ rd_data[6]), 32'h1);
    wait_for(1);
    do_cmd(BE, 4'h8, 32'h0, 1'b1);
    repeat (10) @(posedge clk);
    pin_reset(1'b1);
    check(32'(boot_rom), 32'h1);
    do_read(4'h8, 1'b0);
    check(32'(rd_denied), 32'h1);
    repeat (5) @(posedge clk);
    check(32'(boot_rom), 32'h1);
    wait_for(2);
    @(posedge clk);
    gear_wr <= 1'b1;
    gear_sel <= 3'h2;
    @(posedge clk);
    gear_wr <= 1'b0;
    #1;
    check(32'(gear), 32'h2);
    pin_reset(1'b0);
    check(32'(gear), 32'h0);
    check(32'(boot_rom), 32'h0);
    give_verdict();
  end
endmodule : fbmrc_test
bind fbmrc_top fbmrc_properties #(.PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES), .RECOVER_CYCLES(RECOVER_CYCLES)) u_props (
  .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .CMD_VALID_I(CMD_VALID_I),
  .CMD_CODE_I(CMD_CODE_I), .CMD_ADDR_I(CMD_ADDR_I), .RD_EXT_I(RD_EXT_I),
  .CMD_READY_O(CMD_READY_O), .CMD_REFUSED_O(CMD_REFUSED_O),
  .RD_VALID_O(RD_VALID_O), .RD_DENIED_O(RD_DENIED_O),
  .RD_DATA_O(RD_DATA_O), .CORE_RESET_O(CORE_RESET_O),
  .BOOT_FROM_ROM_O(BOOT_FROM_ROM_O), .CLK_GEAR_O(CLK_GEAR_O),
  .FLASH_BUSY_O(FLASH_BUSY_O), .FLASH_READ_READY_O(FLASH_READ_READY_O),
  .PROTECT_O(PROTECT_O), .READ_LOCK_O(READ_LOCK_O));
`default_nettype wire

// [fbmrc_timer.sv]
// Loadable down-counter that pulses done when its interval runs out.
`default_nettype none
module fbmrc_timer #(
  parameter int W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  fbmrc_tmr_if.cnt tmr
);
  logic [W-1:0] cnt_ff;
  logic done_ff;
  wire last = (cnt_ff == W'(1));
  wire [W-1:0] load_val = (tmr.count == '0) ? W'(1) : tmr.count;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= last & ~tmr.load;
      if (tmr.load) begin
        cnt_ff <= load_val;
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - W'(1);
      end
    end
  end

  assign tmr.busy = (cnt_ff != '0);
  assign tmr.done = done_ff;
endmodule : fbmrc_timer
`default_nettype wire

// [fbmrc_tmr_if.sv]
// Load and completion signals between a controller and its interval timer.
`default_nettype none
interface fbmrc_tmr_if #(parameter int W = 24);
  logic load;
  logic [W-1:0] count;
  logic busy;
  logic done;
  modport ctl (output load, output count, input busy, input done);
  modport cnt (input load, input count, output busy, output done);
endinterface : fbmrc_tmr_if
`default_nettype wire

// [fbmrc_top.sv]
// Reset, start-up source selection and self-timed flash array control.
`default_nettype none

// Overview of operation
// - Strap level during reset picks start-up mode.
// - Strap low at release boots masked ROM.
// - Single-chip mode fetches first from flash.
// - Single-boot mode starts in serial-rewrite ROM.
// - Every reset restores undivided clock gear.
// - Interrupted operation blocks reads about 2 ms.
// - No array reads during erase or write.
// - Array times program and erase itself.
// - Program, chip and block erase, polling status.
// - Block protection only by software command.
// - No erase suspend or resume.
// - Read lock hides contents from external readers.
module fbmrc_top #(
  parameter int DEPTH = 16,
  parameter logic [fbmrc_pkg::TMR_W-1:0] PROG_CYCLES =
    fbmrc_pkg::PROG_CYC,
  parameter logic [fbmrc_pkg::TMR_W-1:0] ERASE_CYCLES =
    fbmrc_pkg::ERASE_CYC,
  parameter logic [fbmrc_pkg::TMR_W-1:0] RECOVER_CYCLES =
    fbmrc_pkg::RECOVER_CYC
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic RESET_N_PIN_I,
  input wire logic PORT_F_LINE_ZERO_I,
  input wire logic GEAR_WR_I,
  input wire logic [fbmrc_pkg::GEAR_W-1:0] GEAR_SEL_I,
  input wire logic CMD_VALID_I,
  input wire logic [fbmrc_pkg::CMD_W-1:0] CMD_CODE_I,
  input wire logic [fbmrc_pkg::ADDR_W-1:0] CMD_ADDR_I,
  input wire logic [fbmrc_pkg::DATA_W-1:0] CMD_DATA_I,
  input wire logic RD_REQ_I,
  input wire logic RD_EXT_I,
  input wire logic [fbmrc_pkg::ADDR_W-1:0] RD_ADDR_I,
  output logic CMD_READY_O,
  output logic CMD_REFUSED_O,
  output logic RD_VALID_O,
  output logic RD_DENIED_O,
  output logic [fbmrc_pkg::DATA_W-1:0] RD_DATA_O,
  output logic CORE_RESET_O,
  output logic BOOT_FROM_ROM_O,
  output logic [fbmrc_pkg::GEAR_W-1:0] CLK_GEAR_O,
  output logic FLASH_BUSY_O,
  output logic FLASH_READ_READY_O,
  output logic [fbmrc_pkg::NUM_BLOCKS-1:0] PROTECT_O,
  output logic READ_LOCK_O
);
  localparam int AW = fbmrc_pkg::ADDR_W;
  localparam int DW = fbmrc_pkg::DATA_W;
  localparam int NB = fbmrc_pkg::NUM_BLOCKS;
  localparam int BW = $clog2(NB);
  localparam int TW = fbmrc_pkg::TMR_W;

  // The block index is the top address bits, used for commands and words.
  function automatic logic [BW-1:0] fn_blk(input logic [AW-1:0] addr);
    fn_blk = addr[AW-1 -: BW];
  endfunction : fn_blk

  // Pin synchronisation.
  logic [1:0] pin_s;
  wire pin_rst_n_s = pin_s[0];
  wire strap_s = pin_s[1];

  fbmrc_sync #(
    .WIDTH(2),
    .RST_VAL({fbmrc_pkg::STRAP_RST, fbmrc_pkg::PIN_RST_N_RST})
  ) u_pin_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .d_i({PORT_F_LINE_ZERO_I, RESET_N_PIN_I}),
    .q_o(pin_s)
  );

  // The pin is taken as reset for as long as it is low; the hold times of
  // the driver are what make the reset, and the clear, trustworthy.
  wire rst_any = RESET_I | ~pin_rst_n_s;

  // Start-up source and clock gear.
  logic boot_rom_ff;
  logic [fbmrc_pkg::GEAR_W-1:0] gear_ff;

  // The strap is followed all through reset, so the value held is the one
  // seen on the last edge before release.
  always_ff @(posedge SYS_CLK_I) begin
    if (rst_any) begin
      boot_rom_ff <= ~strap_s;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (rst_any) begin
      gear_ff <= fbmrc_pkg::GEAR_1_1;
    end else if (GEAR_WR_I) begin
      gear_ff <= GEAR_SEL_I;
    end
  end

  // Timers.
  fbmrc_tmr_if #(.W(TW)) op_tmr ();
  fbmrc_tmr_if #(.W(TW)) rec_tmr ();

  fbmrc_timer #(.W(TW)) u_op_timer (
    .clk_i(SYS_CLK_I),
    .rst_i(rst_any),
    .tmr(op_tmr)
  );

  fbmrc_timer #(.W(TW)) u_rec_timer (
    .clk_i(SYS_CLK_I),
    .rst_i(rst_any),
    .tmr(rec_tmr)
  );

  // Operation state.
  fbmrc_pkg::fbmrc_state_t st_ff;
  fbmrc_pkg::fbmrc_state_t nxt_st;
  logic [AW-1:0] tgt_addr_ff;
  logic [DW-1:0] tgt_data_ff;
  logic [BW-1:0] eblk_ff;
  logic all_ff;
  logic clr_prot_ff;
  logic [NB-1:0] prot_ff;
  logic lock_ff;
  logic intr_ff;
  logic toggle_ff;
  logic refused_ff;
  logic rd_valid_ff;
  logic rd_denied_ff;
  logic [DW-1:0] rd_data_ff;

  wire idle = (st_ff == fbmrc_pkg::ST_IDLE);
  wire busy = ~idle;
  wire op_done = op_tmr.done & busy;

  // Command decode.
  wire [BW-1:0] cmd_blk = fn_blk(CMD_ADDR_I);
  wire cmd_go = CMD_VALID_I & CMD_READY_O;
  wire is_prog = (CMD_CODE_I == fbmrc_pkg::CMD_PROGRAM);
  wire is_berase = (CMD_CODE_I == fbmrc_pkg::CMD_BLOCK_ERASE);
  wire is_cerase = (CMD_CODE_I == fbmrc_pkg::CMD_CHIP_ERASE);
  wire is_prot = (CMD_CODE_I == fbmrc_pkg::CMD_PROTECT);
  wire is_lock = (CMD_CODE_I == fbmrc_pkg::CMD_READ_LOCK);
  wire is_pclr = (CMD_CODE_I == fbmrc_pkg::CMD_PROT_CLEAR);
  wire known = is_prog | is_berase | is_cerase | is_prot | is_lock |
               is_pclr;
  wire blk_locked = prot_ff[cmd_blk];

  // Suspend and resume are not known codes, so they are always refused.
  wire bad_cmd = ~known |
                 ((is_prog | is_berase) & blk_locked) |
                 (is_cerase & (|prot_ff));
  wire refuse = cmd_go & bad_cmd;
  wire accept = cmd_go & ~bad_cmd;
  wire start_prog = accept & is_prog;
  wire start_erase = accept & (is_berase | is_cerase | is_pclr);

  // Operation length; software only starts it, the array times it.
  assign op_tmr.load = start_prog | start_erase;
  assign op_tmr.count = is_prog ? PROG_CYCLES : ERASE_CYCLES;

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      fbmrc_pkg::ST_IDLE: begin
        if (start_prog) begin
          nxt_st = fbmrc_pkg::ST_PROG;
        end else if (start_erase) begin
          nxt_st = fbmrc_pkg::ST_ERASE;
        end
      end
      // An erase ends only at completion or by reset.
      fbmrc_pkg::ST_PROG, fbmrc_pkg::ST_ERASE: begin
        if (op_done) begin
          nxt_st = fbmrc_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st = fbmrc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (rst_any) begin
      st_ff <= fbmrc_pkg::ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (rst_any) begin
      tgt_addr_ff <= '0;
      tgt_data_ff <= '0;
      eblk_ff <= '0;
      all_ff <= 1'b0;
      clr_prot_ff <= 1'b0;
    end else if (accept) begin
      tgt_addr_ff <= CMD_ADDR_I;
      tgt_data_ff <= CMD_DATA_I;
      eblk_ff <= cmd_blk;
      all_ff <= is_cerase | is_pclr;
      clr_prot_ff <= is_pclr;
    end
  end

  // Protection stands for the non-volatile bits: a pin reset leaves it, only power-on
  // and the clear command clear it, and only commands set it, as there is no voltage method.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      prot_ff <= '0;
      lock_ff <= 1'b0;
    end else if (op_done & clr_prot_ff) begin
      prot_ff <= '0;
      lock_ff <= 1'b0;
    end else if (accept & is_prot) begin
      prot_ff[cmd_blk] <= 1'b1;
    end else if (accept & is_lock) begin
      lock_ff <= 1'b1;
    end
  end

  // A pin reset that cuts an operation short starts the read recovery delay.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      intr_ff <= 1'b0;
    end else if (rst_any & busy) begin
      intr_ff <= 1'b1;
    end else if (rec_tmr.load) begin
      intr_ff <= 1'b0;
    end
  end

  assign rec_tmr.load = intr_ff & ~rst_any;
  assign rec_tmr.count = RECOVER_CYCLES;
  wire read_ready = ~rst_any & ~intr_ff & ~rec_tmr.busy;

  // Array words, each updated only when its operation completes.
  logic [DW-1:0] word [DEPTH];

  for (genvar g = 0; g < DEPTH; g++) begin : g_word
    logic [DW-1:0] word_ff;
    wire [AW-1:0] waddr = AW'(g);
    wire hit_erase = op_done & (st_ff == fbmrc_pkg::ST_ERASE) &
                     (all_ff | (fn_blk(waddr) == eblk_ff));
    wire hit_prog = op_done & (st_ff == fbmrc_pkg::ST_PROG) &
                    (tgt_addr_ff == waddr);

    // Programming can only clear bits; a set bit needs an erase.
    always_ff @(posedge SYS_CLK_I) begin
      if (hit_erase) begin
        word_ff <= fbmrc_pkg::ERASED_WORD;
      end else if (hit_prog) begin
        word_ff <= word_ff & tgt_data_ff;
      end
    end

    assign word[g] = word_ff;
  end

  // Status word served instead of array data while an operation runs.
  wire poll_bit = (st_ff == fbmrc_pkg::ST_PROG) ?
                  ~tgt_data_ff[fbmrc_pkg::POLL_BIT] : 1'b0;
  logic [DW-1:0] poll_word;

  always_comb begin
    poll_word = '0;
    poll_word[fbmrc_pkg::POLL_BIT] = poll_bit;
    poll_word[fbmrc_pkg::TOGGLE_BIT] = toggle_ff;
  end

  wire rd_deny = ~read_ready | (RD_EXT_I & lock_ff);

  always_ff @(posedge SYS_CLK_I) begin
    if (rst_any) begin
      toggle_ff <= 1'b0;
    end else if (RD_REQ_I & busy & ~rd_deny) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (rst_any) begin
      rd_valid_ff <= 1'b0;
      rd_denied_ff <= 1'b0;
      rd_data_ff <= '0;
      refused_ff <= 1'b0;
    end else begin
      rd_valid_ff <= RD_REQ_I;
      rd_denied_ff <= RD_REQ_I & rd_deny;
      refused_ff <= refuse;
      if (RD_REQ_I & rd_deny) begin
        rd_data_ff <= '0;
      end else if (RD_REQ_I & busy) begin
        rd_data_ff <= poll_word;
      end else if (RD_REQ_I) begin
        rd_data_ff <= word[RD_ADDR_I];
      end
    end
  end

  // Code that drives an operation must run outside the array, since any
  // read of the array in that time returns the status word, or zero if denied.
  assign CMD_READY_O = idle & ~rst_any;
  assign CMD_REFUSED_O = refused_ff;
  assign RD_VALID_O = rd_valid_ff;
  assign RD_DENIED_O = rd_denied_ff;
  assign RD_DATA_O = rd_data_ff;
  assign CORE_RESET_O = rst_any;
  assign BOOT_FROM_ROM_O = boot_rom_ff;
  assign CLK_GEAR_O = gear_ff;
  assign FLASH_BUSY_O = busy;
  assign FLASH_READ_READY_O = read_ready & idle;
  assign PROTECT_O = prot_ff;
  assign READ_LOCK_O = lock_ff;
endmodule : fbmrc_top
`default_nettype wire
